// ### hdl/atf_pkg.sv
// What this block does
// - the signed error is compared with both thresholds and sets the upper and lower threshold flags.
// - the threshold mode decides whether the comparison outcome sets the threshold interrupt flag.
// - the lower threshold is a writable signed 16-bit value in bits 15:0.
// - the upper threshold is a writable signed 16-bit value in bits 15:0.
// - the error is a read-only signed 16-bit value computed as the calculation select says.
// - the setpoint is a writable signed 16-bit reference for setpoint-based error modes.
// - in accumulate, average and burst-average modes the filter output is the accumulator shifted right by the shift count.
// - in low-pass mode the filter output is the low-pass filter result.
// - the filter output is a read-only signed 16-bit value in bits 15:0.
// - every 16-bit register is reachable as a high byte 15:8 and a low byte 7:0.
// - when the selected threshold condition holds at the end of a computation the threshold interrupt flag sets.
// - the threshold modes are never, below lower, at or above lower, inside inclusive, outside, at or below upper, above upper, always.
// - the error modes are sample derivative, sensing result, result minus setpoint, result minus filter, filter derivative, filter minus setpoint.
// - a set accumulator overflow flag always signals a threshold interrupt.
package atf_pkg;
  localparam int unsigned ATF_ADDR_W = 12;
  localparam logic [11:0] ATF_OFS_LTH    = 12'h08C;
  localparam logic [11:0] ATF_OFS_UTH    = 12'h08E;
  localparam logic [11:0] ATF_OFS_ERR    = 12'h090;
  localparam logic [11:0] ATF_OFS_STPT   = 12'h092;
  localparam logic [11:0] ATF_OFS_FLTR   = 12'h094;
  localparam logic [11:0] ATF_OFS_CTRL   = 12'h0A0;
  localparam logic [11:0] ATF_OFS_STAT   = 12'h0A4;
  localparam logic [11:0] ATF_OFS_IMASK  = 12'h0A8;
  localparam logic [15:0] ATF_RST_16     = 16'h0000;
  localparam logic [7:0]  ATF_RST_CTRL   = 8'h00;
  localparam logic [2:0]  ATF_RST_IMASK  = 3'h0;
  localparam int unsigned ATF_ACC_W      = 18;
  // ctrl field positions
  localparam int unsigned ATF_CTRL_TMD   = 0;
  localparam int unsigned ATF_CTRL_ERROR_SELECT_A  = 3;
  // status/mask bit positions
  localparam int unsigned ATF_ST_TIF     = 0;
  localparam int unsigned ATF_ST_UPPER_THRESHOLD_FLAG    = 1;
  localparam int unsigned ATF_ST_LOWER_THRESHOLD_FLAG    = 2;

  typedef enum logic [2:0] {
    ATF_TM_NEVER   = 3'b000,
    ATF_TM_BELOW   = 3'b001,
    ATF_TM_ATABOVE = 3'b010,
    ATF_TM_INSIDE  = 3'b011,
    ATF_TM_OUTSIDE = 3'b100,
    ATF_TM_ATBELOW = 3'b101,
    ATF_TM_ABOVE   = 3'b110,
    ATF_TM_ALWAYS  = 3'b111
  } atf_tmode_t;

  typedef enum logic [2:0] {
    ATF_CA_DERIV   = 3'b000,
    ATF_CA_SENSE   = 3'b001,
    ATF_CA_RES_SP  = 3'b010,
    ATF_CA_RES_FLT = 3'b011,
    ATF_CA_FDERIV  = 3'b100,
    ATF_CA_FLT_SP  = 3'b101,
    ATF_CA_RSV6    = 3'b110,
    ATF_CA_RSV7    = 3'b111
  } atf_error_select_a_t;

  // computation-unit inputs sampled at end of a computation
  typedef struct packed {
    logic                 done;
    logic                 lowpass_mode;
    logic [2:0]           shift_count;
    logic signed [17:0]   accumulator;
    logic signed [15:0]   lpf_result;
    logic signed [15:0]   result;
    logic signed [15:0]   prev_result;
    logic signed [15:0]   sense_result;
    logic                 accumulator_overflow_flag;
  } atf_comp_t;
endpackage : atf_pkg

// ### hdl/atf_byte_reg.sv
`timescale 1ns/1ps
`default_nettype none
// one 16-bit register with two byte lanes
module atf_byte_reg
  import atf_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        we_lo_i,
  input  wire logic        we_hi_i,
  input  wire logic [7:0]  wdat_lo_i,
  input  wire logic [7:0]  wdat_hi_i,
  output logic      [15:0] q_o
);
  typedef struct packed {
    logic [15:0] val;
  } atf_br_state_t;

  atf_br_state_t st_ff;
  atf_br_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (we_lo_i) begin
      nxt_st.val[7:0] = wdat_lo_i;
    end
    if (we_hi_i) begin
      nxt_st.val[15:8] = wdat_hi_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{val: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.val;
endmodule : atf_byte_reg
`default_nettype wire

// ### hdl/atf_regs.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module atf_regs
  import atf_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ATF_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  input  wire atf_comp_t             comp_i,
  output logic      [2:0]            threshold_mode_o,
  output logic      [2:0]            error_select_a_o,
  output logic                       upper_threshold_flag_o,
  output logic                       lower_threshold_flag_o,
  output logic                       irq_o
);
  typedef struct packed {
    logic [31:0]        dat;
    logic               ack;
    logic               err;
    logic [7:0]         ctrl;
    logic [2:0]         stat;
    logic [2:0]         imask;
    logic signed [15:0] err_val;
    logic signed [15:0] fltr;
    logic signed [15:0] prev_fltr;
  } atf_state_t;

  atf_state_t st_ff;
  atf_state_t nxt_st;

  logic        [15:0] lth_q;
  logic        [15:0] uth_q;
  logic        [15:0] stpt_q;
  logic               req;
  logic               wr;
  logic               hit_lth;
  logic               hit_uth;
  logic               hit_stpt;
  logic signed [15:0] new_fltr;
  logic signed [15:0] new_err;
  logic               ut_flag;
  logic               lt_flag;
  logic               cond;
  logic        [1:0]  lth_lane;
  logic        [1:0]  uth_lane;
  logic        [1:0]  stpt_lane;

  // word-aligned decode: the 16-bit pairs at 0x8C..0x92 share words,
  // so byte lanes select which half of each word a register occupies
  function automatic logic hit16(input logic [11:0] a,
                                 input logic [11:0] ofs);
    hit16 = (a[11:2] == ofs[11:2]);
  endfunction : hit16

  function automatic logic [1:0] lane16(input logic [11:0] ofs,
                                        input logic [3:0]  sel);
    lane16 = ofs[1] ? sel[3:2] : sel[1:0];
  endfunction : lane16

  function automatic logic [31:0] place16(input logic [11:0] ofs,
                                          input logic [15:0] v);
    place16 = ofs[1] ? {v, 16'h0000} : {16'h0000, v};
  endfunction : place16

  assign req      = wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.err;
  assign wr       = req && wb_we_i;
  assign hit_lth  = hit16(wb_adr_i, ATF_OFS_LTH);
  assign hit_uth  = hit16(wb_adr_i, ATF_OFS_UTH);
  assign hit_stpt = hit16(wb_adr_i, ATF_OFS_STPT);
  // a function result cannot be indexed, so the lanes get their own nets
  assign lth_lane  = lane16(ATF_OFS_LTH, wb_sel_i);
  assign uth_lane  = lane16(ATF_OFS_UTH, wb_sel_i);
  assign stpt_lane = lane16(ATF_OFS_STPT, wb_sel_i);

  atf_byte_reg #(.RST_VAL(ATF_RST_16)) u_lth (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_lo_i   (wr && hit_lth && lth_lane[0]),
    .we_hi_i   (wr && hit_lth && lth_lane[1]),
    .wdat_lo_i (wb_dat_i[7:0]),
    .wdat_hi_i (wb_dat_i[15:8]),
    .q_o       (lth_q)
  );

  atf_byte_reg #(.RST_VAL(ATF_RST_16)) u_uth (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_lo_i   (wr && hit_uth && uth_lane[0]),
    .we_hi_i   (wr && hit_uth && uth_lane[1]),
    .wdat_lo_i (wb_dat_i[23:16]),
    .wdat_hi_i (wb_dat_i[31:24]),
    .q_o       (uth_q)
  );

  atf_byte_reg #(.RST_VAL(ATF_RST_16)) u_stpt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_lo_i   (wr && hit_stpt && stpt_lane[0]),
    .we_hi_i   (wr && hit_stpt && stpt_lane[1]),
    .wdat_lo_i (wb_dat_i[23:16]),
    .wdat_hi_i (wb_dat_i[31:24]),
    .q_o       (stpt_q)
  );

  // filter output
  always_comb begin
    if (comp_i.lowpass_mode) begin
      new_fltr = comp_i.lpf_result;
    end else begin
      new_fltr = 16'((comp_i.accumulator >>> comp_i.shift_count));
    end
  end

  // error computation
  always_comb begin
    unique case (atf_error_select_a_t'(st_ff.ctrl[ATF_CTRL_ERROR_SELECT_A +: 3]))
      ATF_CA_DERIV:   new_err = comp_i.result - comp_i.prev_result;
      ATF_CA_SENSE:   new_err = comp_i.sense_result;
      ATF_CA_RES_SP:  new_err = comp_i.result - $signed(stpt_q);
      ATF_CA_RES_FLT: new_err = comp_i.result - new_fltr;
      ATF_CA_FDERIV:  new_err = new_fltr - st_ff.prev_fltr;
      ATF_CA_FLT_SP:  new_err = new_fltr - $signed(stpt_q);
      default:        new_err = 16'h0000; // reserved codes
    endcase
  end

  // threshold tests are signed
  assign ut_flag = new_err > $signed(uth_q);
  assign lt_flag = new_err < $signed(lth_q);

  always_comb begin
    unique case (atf_tmode_t'(st_ff.ctrl[ATF_CTRL_TMD +: 3]))
      ATF_TM_NEVER:   cond = 1'b0;
      ATF_TM_BELOW:   cond = lt_flag;
      ATF_TM_ATABOVE: cond = !lt_flag;
      ATF_TM_INSIDE:  cond = !lt_flag && !ut_flag;
      ATF_TM_OUTSIDE: cond = lt_flag || ut_flag;
      ATF_TM_ATBELOW: cond = !ut_flag;
      ATF_TM_ABOVE:   cond = ut_flag;
      ATF_TM_ALWAYS:  cond = 1'b1;
    endcase
  end

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.err = 1'b0;
    nxt_st.dat = 32'h0000_0000;
    if (comp_i.done) begin
      nxt_st.err_val   = new_err;
      nxt_st.fltr      = new_fltr;
      nxt_st.prev_fltr = new_fltr;
      nxt_st.stat[ATF_ST_UPPER_THRESHOLD_FLAG] = ut_flag;
      nxt_st.stat[ATF_ST_LOWER_THRESHOLD_FLAG] = lt_flag;
    end
    if (req) begin
      unique case (wb_adr_i[11:2])
        ATF_OFS_LTH[11:2]: begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = {uth_q, lth_q};
        end
        ATF_OFS_ERR[11:2]: begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = {stpt_q, st_ff.err_val};
        end
        ATF_OFS_FLTR[11:2]: begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = place16(ATF_OFS_FLTR, st_ff.fltr);
        end
        ATF_OFS_CTRL[11:2]: begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = {24'h000000, st_ff.ctrl};
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_st.ctrl = wb_dat_i[7:0];
          end
        end
        ATF_OFS_STAT[11:2]: begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = {29'h00000000, st_ff.stat};
          // reads clear the sticky interrupt flag
          if (!wb_we_i) begin
            nxt_st.stat[ATF_ST_TIF] = 1'b0;
          end
        end
        ATF_OFS_IMASK[11:2]: begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = {29'h00000000, st_ff.imask};
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_st.imask = wb_dat_i[2:0];
          end
        end
        default: nxt_st.err = 1'b1;
      endcase
    end
    // set wins over a read clear in the same cycle
    if (comp_i.done && (cond || comp_i.accumulator_overflow_flag)) begin
      nxt_st.stat[ATF_ST_TIF] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{dat: 32'h0000_0000, ack: 1'b0, err: 1'b0,
                 ctrl: ATF_RST_CTRL, stat: 3'h0, imask: ATF_RST_IMASK,
                 err_val: 16'h0000, fltr: 16'h0000,
                 prev_fltr: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o               = st_ff.dat;
  assign wb_ack_o               = st_ff.ack;
  assign wb_err_o               = st_ff.err;
  assign threshold_mode_o       = st_ff.ctrl[ATF_CTRL_TMD +: 3];
  assign error_select_a_o       = st_ff.ctrl[ATF_CTRL_ERROR_SELECT_A +: 3];
  assign upper_threshold_flag_o = st_ff.stat[ATF_ST_UPPER_THRESHOLD_FLAG];
  assign lower_threshold_flag_o = st_ff.stat[ATF_ST_LOWER_THRESHOLD_FLAG];
  assign irq_o                  = |(st_ff.stat & st_ff.imask);
endmodule : atf_regs
`default_nettype wire

// ### bench/atf_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module atf_regs_asserts
  import atf_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [ATF_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  wb_err_o,
  input wire atf_comp_t             comp_i,
  input wire logic [2:0]            threshold_mode_o,
  input wire logic [2:0]            error_select_a_o,
  input wire logic                  upper_threshold_flag_o,
  input wire logic                  lower_threshold_flag_o,
  input wire logic                  irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bus_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o
    && !wb_err_o) |=> (wb_ack_o || wb_err_o)) else $error("no answer");
  a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i)
    |=> !wb_ack_o && !wb_err_o) else $error("answer while idle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_one_answer: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack with err");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_flags_hold: assert property (!$past(comp_i.done) |->
    $stable(upper_threshold_flag_o) && $stable(lower_threshold_flag_o))
    else $error("flag moved without done");
  a_ctrl_hold: assert property (!(wb_ack_o && wb_we_i) |->
    $stable(threshold_mode_o) && $stable(error_select_a_o))
    else $error("ctrl moved without write");
  a_irq_rise: assert property ($rose(irq_o) |->
    $past(comp_i.done) || (wb_ack_o && wb_we_i)) else $error("stray irq");
  a_irq_fall: assert property ($fell(irq_o) |->
    $past(comp_i.done) || wb_ack_o) else $error("irq dropped alone");
endmodule : atf_regs_asserts
bind atf_regs atf_regs_asserts atf_regs_asserts_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .comp_i, .threshold_mode_o,
  .error_select_a_o, .upper_threshold_flag_o, .lower_threshold_flag_o,
  .irq_o);
`default_nettype wire

// ### bench/atf_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, x); end end
module atf_regs_tb
  import atf_pkg::*;
;
  logic               clk_i, rst_i, cyc, stb, we, ack, err, e, uf, lf, irq;
  logic [11:0]        adr;
  logic [3:0]         sel;
  logic [31:0]        wdat, rdat, q;
  logic [2:0]         tm_o, ca_o, tm, ca, m, st;
  logic signed [15:0] lo, up, sp, er, f;
  atf_comp_t          comp;
  int                 miscompares, n_checks, cyc_n, seed;
  atf_regs atf_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .comp_i(comp), .threshold_mode_o(tm_o), .error_select_a_o(ca_o),
    .upper_threshold_flag_o(uf), .lower_threshold_flag_o(lf), .irq_o(irq));
  function automatic logic signed [15:0] exp_err(logic [2:0] c,
    logic signed [15:0] r, p, s, t, fv);
    case (c)
      3'h0: return r - p;
      3'h1: return s;
      3'h2: return r - t;
      3'h3: return r - fv;
      3'h4: return 16'h0000;
      3'h5: return fv - t;
      default: return 16'h0000;
    endcase
  endfunction : exp_err
  function automatic logic hit(logic [2:0] t, logic signed [15:0] v, l, u);
    case (t)
      3'h0: return 1'b0;
      3'h1: return v < l;
      3'h2: return v >= l;
      3'h3: return v >= l && v <= u;
      3'h4: return v < l || v > u;
      3'h5: return v <= u;
      3'h6: return v > u;
      default: return 1'b1;
    endcase
  endfunction : hit
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic pulse;
    comp.done <= 1'b1;
    @(posedge clk_i);
    comp.done <= 1'b0;
    @(posedge clk_i);
  endtask : pulse
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard: the run needs about two thousand cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    comp = '0;
    seed = 32'h5E9F2838;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // words 0x98 and 0x9C are unmapped and must answer with err
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, ATF_OFS_LTH + 12'(i * 4), 4'hF, 32'h0);
      `CHK(q, 32'h0)
      `CHK(e, (i == 3 || i == 4))
    end
    xfer(1'b0, 12'h0F0, 4'hF, 32'h0);
    `CHK(e, 1'b1)
    xfer(1'b1, 12'h08C, 4'h5, 32'h11223344);
    xfer(1'b1, 12'h08C, 4'hA, 32'h55667788);
    xfer(1'b0, 12'h08C, 4'hF, 32'h0);
    `CHK(q, 32'h55227744)
    xfer(1'b1, 12'h090, 4'hF, 32'hAAAABBBB);
    xfer(1'b1, 12'h094, 4'hF, 32'hFFFFFFFF);
    xfer(1'b0, 12'h090, 4'hF, 32'h0);
    `CHK(q, 32'hAAAA0000)
    xfer(1'b0, 12'h094, 4'hF, 32'h0);
    `CHK(q[15:0], 16'h0000)
    for (int i = 0; i < 64; i++) begin
      {lo, up} = {16'($random(seed)), 16'($random(seed))};
      m = 3'($random(seed));
      sp = 16'($random(seed) % 8192);
      {tm, ca} = {3'(i), 3'(i / 8)};
      comp.result <= 16'($random(seed) % 8192);
      comp.prev_result <= 16'($random(seed) % 8192);
      comp.sense_result <= 16'($random(seed) % 8192);
      comp.lpf_result <= 16'($random(seed) % 8192);
      comp.accumulator <= 18'($random(seed) % 16384);
      comp.shift_count <= 3'($random(seed));
      comp.lowpass_mode <= 1'($random(seed));
      comp.accumulator_overflow_flag <= ($random(seed) % 8 == 0);
      xfer(1'b1, 12'h08C, 4'hF, {up, lo});
      xfer(1'b1, 12'h090, 4'hC, {sp, 16'h0});
      xfer(1'b1, 12'h0A0, 4'h1, {26'h0, ca, tm});
      xfer(1'b1, 12'h0A8, 4'h1, {29'h0, m});
      `CHK({ca_o, tm_o}, {ca, tm})
      // second identical done keeps the filter history steady
      pulse();
      xfer(1'b0, 12'h0A4, 4'hF, 32'h0);
      pulse();
      f = comp.lowpass_mode ? comp.lpf_result
        : 16'($signed(comp.accumulator) >>> comp.shift_count);
      er = exp_err(ca, comp.result, comp.prev_result, comp.sense_result,
        sp, f);
      st = {er < lo, er > up,
        hit(tm, er, lo, up) | comp.accumulator_overflow_flag};
      `CHK(irq, |(st & m))
      `CHK({lf, uf}, st[2:1])
      xfer(1'b0, 12'h0A4, 4'hF, 32'h0);
      `CHK(q[2:0], st)
      xfer(1'b0, 12'h0A4, 4'hF, 32'h0);
      `CHK(q[0], 1'b0)
      xfer(1'b0, 12'h090, 4'hF, 32'h0);
      `CHK(q[15:0], er)
      xfer(1'b0, 12'h094, 4'hF, 32'h0);
      `CHK(q[15:0], f)
    end
    wrap_up();
  end
endmodule : atf_regs_tb
`default_nettype wire
